// ===== src/adcs_pkg.sv
package adcs_pkg;

   // converter timing, in converter clock ticks
   localparam int unsigned NORMAL_TICKS = 13;
   localparam int unsigned FIRST_TICKS = 25;

   // result code layout
   localparam int unsigned CODE_W = 10;
   localparam logic [9:0] CODE_FULL_SCALE = 10'h3ff;
   localparam logic [9:0] CODE_GROUND = 10'h000;
   localparam int unsigned CODE_STEPS_SHIFT = 10;

   // fixed bandgap-derived reference, in millivolts
   localparam logic [15:0] BANDGAP_MV = 16'h044c;

   // reference source field encodings
   localparam logic [1:0] REF_EXTERNAL = 2'h0;
   localparam logic [1:0] REF_SUPPLY = 2'h1;
   localparam logic [1:0] REF_RESERVED = 2'h2;
   localparam logic [1:0] REF_BANDGAP = 2'h3;

   // reset values
   localparam logic [9:0] RESULT_RESET = 10'h000;
   localparam logic [1:0] REF_RESET = 2'h0;

   // sleep modes reported by the sleep controller
   typedef enum logic [2:0] {
      ADCS_SLEEP_IDLE = 3'b000,
      ADCS_SLEEP_NOISE_RED = 3'b001,
      ADCS_SLEEP_POWER_DOWN = 3'b010,
      ADCS_SLEEP_POWER_SAVE = 3'b011,
      ADCS_SLEEP_STANDBY = 3'b110,
      ADCS_SLEEP_EXT_STANDBY = 3'b111
   } adcs_sleep_t;

   // converter sequencing states
   typedef enum logic [0:0] {
      ADCS_ST_IDLE = 1'b0,
      ADCS_ST_CONVERT = 1'b1
   } adcs_state_t;

   // software control bits
   typedef struct packed {
      logic converter_enable;
      logic conversion_start_wr;
      logic conversion_irq_enable;
      logic result_left_align;
      logic [1:0] reference_source_field;
      logic done_flag_clear_wr;
   } adcs_ctrl_t;

   // analog levels already digitised by the front end, millivolts
   typedef struct packed {
      logic [15:0] input_mv;
      logic [15:0] analog_supply_reference_mv;
      logic [15:0] external_reference_pin_mv;
   } adcs_analog_t;

   // sleep controller handshake
   typedef struct packed {
      logic cpu_halted;
      adcs_sleep_t sleep_mode;
      logic irq_vector_ack;
   } adcs_sleep_if_t;

endpackage

// ===== src/adcs_format.sv
`timescale 1ns/1ps

// places the held code into the two result bytes
module adcs_format (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // held code and alignment
   input wire logic [9:0] code,
   input wire logic result_left_align,
   // result bytes
   output logic [7:0] result_low_byte,
   output logic [7:0] result_high_byte
);

   // bytes re-formed every cycle, so the alignment acts at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         result_low_byte <= 8'h00;
         result_high_byte <= 8'h00;
      end else if (result_left_align) begin
         // left adjusted: high holds 9:2, low 7:6 holds 1:0
         result_high_byte <= code[9:2]; // RL21 RL16
         result_low_byte <= {code[1:0], 6'h00}; // RL21
      end else begin
         // right adjusted: low holds 7:0, high 1:0 holds 9:8
         result_low_byte <= code[7:0]; // RL20 RL15
         result_high_byte <= {6'h00, code[9:8]}; // RL20
      end
   end

endmodule

// ===== src/adcs_ctrl.sv
`timescale 1ns/1ps

// Notes on behaviour
// RL1: reference chosen from supply, bandgap, external pin
// RL2: input above reference gives full-scale code
// RL3: software drops first result after reference switch
// RL4: sleep start only in noise-reduction or idle
// RL5: caller enables, idles, single mode, irq before sleep
// RL6: conversion starts once cpu clock halted
// RL7: done interrupt wakes cpu when nothing earlier
// RL8: earlier wake still leaves done request raised
// RL9: cpu stays active until next sleep
// RL10: other sleep modes never disable the converter
// RL11: caller keeps converter pins quiet while converting
// RL12: code is input times 1024 over reference
// RL13: zero is ground, full scale is ref minus step
// RL14: result readable once done flag sets
// RL15: alignment cleared gives right-adjusted bytes
// RL16: alignment set gives left-adjusted, acts immediately
// RL17: low-byte read freezes result until high read
// RL18: done flag cleared by vector or written one
// RL19: normal conversion 13 ticks, first 25
// RL20: right form: low 7:0, high 1:0 hold 9:8
// RL21: left form: high holds 9:2, low 7:6 holds 1:0
module adcs_ctrl (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // converter clock tick from the prescaler, same domain
   input wire logic conv_tick,
   // software control bits
   input wire adcs_pkg::adcs_ctrl_t ctrl,
   // analog front end levels, from outside the clock domain
   input wire adcs_pkg::adcs_analog_t analog,
   // sleep controller
   input wire adcs_pkg::adcs_sleep_if_t sleep_if,
   // result byte read strobes
   input wire logic result_low_read,
   input wire logic result_high_read,
   // status
   output logic conversion_start_bit,
   output logic conversion_done_flag,
   output logic conversion_irq,
   output logic cpu_wake,
   output logic [1:0] active_reference,
   // result bytes
   output logic [7:0] result_low_byte,
   output logic [7:0] result_high_byte
);

   adcs_pkg::adcs_state_t state_r; // sequencing state
   logic [4:0] tick_cnt_r; // ticks left in the conversion
   logic first_pending_r; // next conversion is the long first one
   logic [1:0] ref_sel_r; // reference locked for this conversion
   logic [9:0] code_r; // held result code
   logic read_lock_r; // low byte read, high not yet
   logic halted_d_r; // previous cpu halted level
   logic sleep_started_r; // running conversion began from sleep
   logic [15:0] vin_s1_r, vin_s2_r; // input synchroniser
   logic [15:0] sup_s1_r, sup_s2_r; // supply reference synchroniser
   logic [15:0] ext_s1_r, ext_s2_r; // external reference synchroniser
   logic [15:0] vin_hold_r; // sampled input for this conversion
   logic sleep_start; // sleep-triggered start request
   logic start_req; // any start request
   logic finish; // last tick of a conversion
   logic [15:0] vref_mv; // selected reference level
   logic [25:0] quotient; // raw ratio
   logic [9:0] new_code; // saturated code
   logic [9:0] code_nxt; // code the next edge will hold

   // true for the sleep modes that may start a conversion
   function automatic logic sleep_mode_ok(input adcs_pkg::adcs_sleep_t m);
      sleep_mode_ok = (m == adcs_pkg::ADCS_SLEEP_IDLE) ||
                      (m == adcs_pkg::ADCS_SLEEP_NOISE_RED);
   endfunction

   // two-flop capture of the analog levels
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         vin_s1_r <= 16'h0000;
         vin_s2_r <= 16'h0000;
         sup_s1_r <= 16'h0000;
         sup_s2_r <= 16'h0000;
         ext_s1_r <= 16'h0000;
         ext_s2_r <= 16'h0000;
      end else begin
         vin_s1_r <= analog.input_mv;
         vin_s2_r <= vin_s1_r;
         sup_s1_r <= analog.analog_supply_reference_mv;
         sup_s2_r <= sup_s1_r;
         ext_s1_r <= analog.external_reference_pin_mv;
         ext_s2_r <= ext_s1_r;
      end
   end

   // start on a fresh halt edge in an allowed mode; a later wake
   // leaves the cpu active because only a new halt edge re-arms this
   assign sleep_start = sleep_if.cpu_halted && !halted_d_r &&
                        sleep_mode_ok(sleep_if.sleep_mode) &&
                        ctrl.converter_enable; // RL4 RL6 RL9 RL5
   assign start_req = ctrl.converter_enable &&
                      (ctrl.conversion_start_wr || sleep_start);
   assign finish = (state_r == adcs_pkg::ADCS_ST_CONVERT) && conv_tick &&
                   (tick_cnt_r == 5'h01);

   // halt edge detection
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         halted_d_r <= 1'b0;
      end else begin
         halted_d_r <= sleep_if.cpu_halted;
      end
   end

   // conversion sequencing; disable aborts, nothing else does
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= adcs_pkg::ADCS_ST_IDLE;
         tick_cnt_r <= 5'h00;
         vin_hold_r <= 16'h0000;
      end else if (!ctrl.converter_enable) begin
         // other sleep modes never reach here by themselves
         state_r <= adcs_pkg::ADCS_ST_IDLE; // RL10
         tick_cnt_r <= 5'h00;
      end else begin
         unique case (state_r)
            adcs_pkg::ADCS_ST_IDLE: begin
               // load 25 for the first conversion, else 13
               if (start_req) begin
                  state_r <= adcs_pkg::ADCS_ST_CONVERT;
                  tick_cnt_r <= first_pending_r ? 5'(adcs_pkg::FIRST_TICKS)
                                                : 5'(adcs_pkg::NORMAL_TICKS); // RL19
                  vin_hold_r <= vin_s2_r;
               end
            end
            adcs_pkg::ADCS_ST_CONVERT: begin
               // count converter ticks down to the end
               if (finish) begin
                  state_r <= adcs_pkg::ADCS_ST_IDLE;
                  tick_cnt_r <= 5'h00;
               end else if (conv_tick) begin
                  tick_cnt_r <= tick_cnt_r - 5'h01;
               end
            end
         endcase
      end
   end

   // first-conversion marker, re-armed whenever disabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         first_pending_r <= 1'b1;
      end else if (!ctrl.converter_enable) begin
         first_pending_r <= 1'b1;
      end else if (start_req && state_r == adcs_pkg::ADCS_ST_IDLE) begin
         first_pending_r <= 1'b0;
      end
   end

   // reference follows software while idle, locked while converting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_sel_r <= adcs_pkg::REF_RESET;
      end else if (state_r == adcs_pkg::ADCS_ST_IDLE && !start_req) begin
         ref_sel_r <= ctrl.reference_source_field; // RL1
      end
   end

   // reference level for the locked selection
   always_comb begin
      unique case (ref_sel_r)
         adcs_pkg::REF_SUPPLY: vref_mv = sup_s2_r; // RL1
         adcs_pkg::REF_BANDGAP: vref_mv = adcs_pkg::BANDGAP_MV; // RL1
         adcs_pkg::REF_EXTERNAL: vref_mv = ext_s2_r; // RL1
         adcs_pkg::REF_RESERVED: vref_mv = sup_s2_r;
      endcase
   end

   // code = vin * 1024 / vref, truncated; ground is zero
   always_comb begin
      quotient = 26'h0000000;
      new_code = adcs_pkg::CODE_FULL_SCALE;
      if (vref_mv != 16'h0000) begin
         quotient = ({10'h000, vin_hold_r} << adcs_pkg::CODE_STEPS_SHIFT) /
                    {10'h000, vref_mv}; // RL12 RL13
         // above the reference the code pins at full scale
         if (quotient > {16'h0000, adcs_pkg::CODE_FULL_SCALE}) begin
            new_code = adcs_pkg::CODE_FULL_SCALE; // RL2 RL13
         end else begin
            new_code = quotient[9:0]; // RL12
         end
      end
   end

   // result bytes held off between a low read and a high read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         read_lock_r <= 1'b0;
      end else if (result_high_read) begin
         read_lock_r <= 1'b0; // RL17
      end else if (result_low_read) begin
         read_lock_r <= 1'b1; // RL17
      end
   end

   // next held code: new result at the finish unless a pair read is pending
   assign code_nxt = (finish && !read_lock_r) ? new_code : code_r; // RL14 RL17

   // result stored at the finish unless frozen by a pending pair read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_r <= adcs_pkg::RESULT_RESET;
      end else begin
         code_r <= code_nxt; // RL14 RL17
      end
   end

   // done flag: set wins over vector ack or write-one clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         conversion_done_flag <= 1'b0;
      end else if (finish) begin
         conversion_done_flag <= 1'b1; // RL14 RL8
      end else if (sleep_if.irq_vector_ack || ctrl.done_flag_clear_wr) begin
         conversion_done_flag <= 1'b0; // RL18
      end
   end

   // remembers that the running conversion began from sleep
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_started_r <= 1'b0;
      end else if (state_r == adcs_pkg::ADCS_ST_IDLE) begin
         sleep_started_r <= sleep_start;
      end else if (finish) begin
         sleep_started_r <= 1'b0;
      end
   end

   // wake pulse when a sleep-started conversion ends with cpu still halted and the conversion interrupt enabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_wake <= 1'b0;
      end else begin
         cpu_wake <= finish && sleep_started_r && sleep_if.cpu_halted &&
                     ctrl.conversion_irq_enable; // RL7
      end
   end

   // interrupt request level, raised even if cpu already woke
   assign conversion_irq = conversion_done_flag && ctrl.conversion_irq_enable; // RL7 RL8
   assign conversion_start_bit = (state_r == adcs_pkg::ADCS_ST_CONVERT);
   assign active_reference = ref_sel_r;

   // byte placement; fed the next code so bytes change with the done flag
   adcs_format u_format (
      .clk(clk),
      .rst_n(rst_n),
      .code(code_nxt), // RL14
      .result_left_align(ctrl.result_left_align),
      .result_low_byte(result_low_byte),
      .result_high_byte(result_high_byte)
   );

endmodule

// ===== sim/adcs_ctrl_monitor.sv
`timescale 1ns/1ps
// watches the converter control ports
module adcs_ctrl_monitor (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // inputs
   input wire logic conv_tick,
   input wire adcs_pkg::adcs_ctrl_t ctrl,
   input wire adcs_pkg::adcs_sleep_if_t sleep_if,
   // outputs
   input wire logic conversion_start_bit,
   input wire logic conversion_done_flag,
   input wire logic cpu_wake,
   input wire logic [1:0] active_reference,
   input wire logic [7:0] result_low_byte,
   input wire logic [7:0] result_high_byte
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // sleep modes that may start a conversion
   wire logic ok_mode = sleep_if.sleep_mode inside {adcs_pkg::ADCS_SLEEP_IDLE,
      adcs_pkg::ADCS_SLEEP_NOISE_RED};
   AST_START: assert property (
      ctrl.conversion_start_wr && ctrl.converter_enable && !conversion_start_bit
      |=> conversion_start_bit) else $error("start not taken");
   AST_SLEEP_GO: assert property (
      $rose(sleep_if.cpu_halted) && ok_mode && ctrl.converter_enable && !conversion_start_bit
      |=> conversion_start_bit) else $error("sleep start missing");
   AST_SLEEP_NO: assert property (
      $rose(sleep_if.cpu_halted) && !ok_mode && !ctrl.conversion_start_wr
      && !conversion_start_bit |=> !conversion_start_bit) else $error("sleep start in bad mode");
   AST_HOLD: assert property (
      conversion_start_bit && ctrl.converter_enable && !conv_tick |=> conversion_start_bit)
      else $error("conversion ended without a tick");
   AST_DONE: assert property (
      $fell(conversion_start_bit) && $past(ctrl.converter_enable) |-> conversion_done_flag)
      else $error("finish without done flag");
   AST_CLEAR: assert property (
      conversion_done_flag && (ctrl.done_flag_clear_wr || sleep_if.irq_vector_ack)
      && !(conversion_start_bit && conv_tick) |=> !conversion_done_flag)
      else $error("done flag not cleared");
   AST_WAKE: assert property (
      cpu_wake |-> $past(conversion_start_bit) && conversion_done_flag ##1 !cpu_wake)
      else $error("bad wake pulse");
   AST_RIGHT: assert property (
      $past(ctrl.result_left_align) == 1'b0 |-> result_high_byte[7:2] == 6'h00)
      else $error("right form high bits set");
   AST_LEFT: assert property (
      $past(ctrl.result_left_align) |-> result_low_byte[5:0] == 6'h00)
      else $error("left form low bits set");
   AST_REF_LOCK: assert property (
      conversion_start_bit && $past(conversion_start_bit) |-> $stable(active_reference))
      else $error("reference moved in conversion");
   // main scenarios
   cover property (cpu_wake);
   cover property ($fell(conversion_start_bit) && ctrl.result_left_align);
   cover property (conversion_done_flag && sleep_if.irq_vector_ack);
endmodule
bind adcs_ctrl adcs_ctrl_monitor i_adcs_ctrl_monitor (.clk, .rst_n, .conv_tick, .ctrl,
   .sleep_if, .conversion_start_bit, .conversion_done_flag, .cpu_wake, .active_reference,
   .result_low_byte, .result_high_byte);

// ===== sim/adcs_cpu_model.sv
`timescale 1ns/1ps
// cpu core with sleep controller, as the converter sees it
module adcs_cpu_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // bench commands
   input wire logic sleep_cmd,
   input wire adcs_pkg::adcs_sleep_t sleep_mode_cmd,
   input wire logic other_irq,
   // from the converter
   input wire logic conversion_irq,
   input wire logic cpu_wake,
   // to the converter
   output adcs_pkg::adcs_sleep_if_t sleep_if
);
   // halt on sleep, wake on a source, run the vector only when awake
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_if <= '0;
      end else begin
         if (sleep_cmd) begin
            sleep_if.cpu_halted <= 1'b1;
            sleep_if.sleep_mode <= sleep_mode_cmd;
         end else if (cpu_wake || other_irq) begin
            sleep_if.cpu_halted <= 1'b0;
         end
         sleep_if.irq_vector_ack <= conversion_irq && !sleep_if.cpu_halted
            && !sleep_if.irq_vector_ack;
      end
   end
endmodule

// ===== sim/adcs_ctrl_tb.sv
`timescale 1ns/1ps
// bench for the converter control slice
module adcs_ctrl_tb;
   logic clk, rst_n, conv_tick, sleep_cmd, other_irq, rd_lo, rd_hi;
   logic sbit, flag, irq, wake;
   logic [1:0] external_reference_pin;
   logic [7:0] lo, hi;
   adcs_pkg::adcs_ctrl_t ctrl; // software bits
   adcs_pkg::adcs_analog_t an; // levels in mv
   adcs_pkg::adcs_sleep_if_t sif; // cpu side
   adcs_pkg::adcs_sleep_t mode; // requested sleep mode
   int errors, samples_checked, ticks, cycles;
   adcs_ctrl i_adcs_ctrl (.clk, .rst_n, .conv_tick, .ctrl, .analog(an), .sleep_if(sif),
      .result_low_read(rd_lo), .result_high_read(rd_hi), .conversion_start_bit(sbit),
      .conversion_done_flag(flag), .conversion_irq(irq), .cpu_wake(wake),
      .active_reference(external_reference_pin), .result_low_byte(lo), .result_high_byte(hi));
   adcs_cpu_model i_adcs_cpu_model (.clk, .rst_n, .sleep_cmd, .sleep_mode_cmd(mode),
      .other_irq, .conversion_irq(irq), .cpu_wake(wake), .sleep_if(sif));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // tick every fourth clock, count ticks in conversions
   always @(posedge clk) begin
      if (sbit && conv_tick) ticks++;
      cycles++;
      #2 conv_tick = (cycles % 4 == 0);
   end
   // cut hangs: a run this long counts as a mismatch
   always @(posedge clk) begin
      if (cycles >= 10000) begin
         errors++;
         stop_test();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic chk(input string s, input logic [9:0] e, input logic [9:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", s, e, g);
      end
   endtask
   // wait for the finish, then one cycle for the bytes
   task automatic fin();
      for (int n = 0; n < 300 && sbit !== 1'b0; n++) step(1);
      step(1);
      chk("busy", 10'h000, {9'h000, sbit});
   endtask
   // software start; levels stay put meanwhile
   task automatic conv();
      ctrl.conversion_start_wr = 1'b1;
      step(1);
      ctrl.conversion_start_wr = 1'b0;
      fin();
   endtask
   // both byte forms of one code
   task automatic bytes(input logic [9:0] c);
      chk("low r", {2'h0, c[7:0]}, {2'h0, lo});
      chk("high r", {8'h00, c[9:8]}, {2'h0, hi});
      ctrl.result_left_align = 1'b1;
      step(1);
      chk("high l", {2'h0, c[9:2]}, {2'h0, hi});
      chk("low l", {2'h0, c[1:0], 6'h00}, {2'h0, lo});
      ctrl.result_left_align = 1'b0;
      step(1);
   endtask
   task automatic t_reference_source_field();
      int fl[5] = '{0, 1, 2, 3, 3};
      int vi[5] = '{500, 4000, 1650, 1000, 0};
      int vr[5] = '{1000, 3300, 3300, 1100, 1100};
      int c;
      ctrl.converter_enable = 1'b1;
      conv();
      chk("first", 10'h019, ticks[9:0]);
      for (int i = 0; i < 5; i++) begin
         ctrl.reference_source_field = fl[i][1:0];
         an.input_mv = vi[i][15:0];
         step(1);
         chk("ref", {8'h00, fl[i][1:0]}, {8'h00, external_reference_pin});
         conv();
         ticks = 0;
         conv();
         chk("ticks", 10'h00d, ticks[9:0]);
         c = vi[i] * 1024 / vr[i];
         bytes(c > 1023 ? 10'h3ff : c[9:0]);
      end
      $display("t_reference_source_field done");
   endtask
   task automatic t_lock();
      ctrl.reference_source_field = 2'h0;
      an.input_mv = 16'h00fa;
      conv();
      conv();
      rd_lo = 1'b1;
      step(1);
      rd_lo = 1'b0;
      an.input_mv = 16'h02ee;
      step(2);
      conv();
      chk("held", 10'h100, {hi[1:0], lo});
      chk("flag", 10'h001, {9'h000, flag});
      rd_hi = 1'b1;
      ctrl.done_flag_clear_wr = 1'b1;
      step(1);
      rd_hi = 1'b0;
      ctrl.done_flag_clear_wr = 1'b0;
      step(1);
      chk("cleared", 10'h000, {9'h000, flag});
      conv();
      bytes(10'h300);
      // disable aborts a running conversion and re-arms the long first one
      ctrl.conversion_start_wr = 1'b1;
      step(1);
      ctrl.conversion_start_wr = 1'b0;
      ctrl.converter_enable = 1'b0;
      step(1);
      chk("abort", 10'h000, {9'h000, sbit});
      ctrl.converter_enable = 1'b1;
      ticks = 0;
      conv();
      chk("re-enable", 10'h019, ticks[9:0]);
      $display("t_lock done");
   endtask
   task automatic sleep(input adcs_pkg::adcs_sleep_t m);
      mode = m;
      sleep_cmd = 1'b1;
      step(1);
      sleep_cmd = 1'b0;
      step(3);
   endtask
   task automatic wake_up();
      other_irq = 1'b1;
      step(1);
      other_irq = 1'b0;
      step(4);
   endtask
   task automatic t_sleep();
      ctrl.conversion_irq_enable = 1'b1;
      step(4);
      for (int m = 0; m < 2; m++) begin
         sleep(adcs_pkg::adcs_sleep_t'(m));
         chk("sleep start", 10'h001, {9'h000, sbit});
         fin();
         step(4);
         chk("woke", 10'h000, {9'h000, sif.cpu_halted});
         chk("vector", 10'h000, {9'h000, flag});
      end
      ctrl.conversion_start_wr = 1'b1;
      step(1);
      ctrl.conversion_start_wr = 1'b0;
      sleep(adcs_pkg::ADCS_SLEEP_POWER_DOWN);
      fin();
      chk("kept", 10'h001, {9'h000, flag});
      wake_up();
      sleep(adcs_pkg::ADCS_SLEEP_STANDBY);
      chk("no start", 10'h000, {9'h000, sbit});
      wake_up();
      sleep(adcs_pkg::ADCS_SLEEP_IDLE);
      wake_up();
      chk("early wake", 10'h001, {9'h000, sbit});
      for (int n = 0; n < 300 && irq !== 1'b1; n++) step(1);
      chk("late irq", 10'h001, {9'h000, irq});
      $display("t_sleep done");
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      ctrl = '0;
      an = {16'h01f4, 16'h0ce4, 16'h03e8};
      {sleep_cmd, other_irq, rd_lo, rd_hi} = 4'h0;
      mode = adcs_pkg::ADCS_SLEEP_IDLE;
      step(16);
      rst_n = 1'b1;
      t_reference_source_field();
      t_lock();
      t_sleep();
      stop_test();
   end
endmodule
